// ==== design/ccd_core.sv ====
// cpu core register and control section with wishbone view
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - latch the opcode from the data lines during the opcode fetch.
// - cycle step counter returns to zero at each instruction fetch.
// - step counter advances every cycle until the instruction completes.
// - transfer controls come from decoding opcode and step together.
// - one 16-bit ALU does data operations; address sums use separate adders.
// - ALU results go to the accumulator, except compare, which only sets flags; flags may update.
// - native mode accumulator is 16 bits when width flag zero, else 8.
// - narrow mode keeps accumulator high byte; swap exchanges the bytes.
// - data bank byte sits above the 16-bit address for data accesses.
// - bank value drives data lines in first half of data cycles.
// - reset clears the data bank register.
// - 16-bit datapath, 8-bit data pins, 24-bit address from bank.
// - abort stops the current instruction's final register update; fetches still advance the PC.
// - valid data and valid program address outputs driven each cycle.
// - vector fetch output active during every vector read cycle.
// - software switches between emulation mode and native mode.
// - every one of the 256 opcodes has a defined operation.
// - emulation mode forces both width select flags to one.
// - bank in first half of cycle, data in second; 16 bits take two.
module ccd_core
  import ccd_pkg::*;
#(
  parameter int HALF = HALF_TICKS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [15:0] addrOut,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe_n,
  output logic readNotWrite,
  output logic validDataAddr,
  output logic validProgramAddr,
  output logic vectorFetch_n,
  input wire logic abortInput_n,
  output logic emulationOut
);
  localparam logic [TICK_W-1:0] LAST_TICK = TICK_W'(2 * HALF - 1);
  localparam logic [TICK_W-1:0] HALF_TICK = TICK_W'(HALF);

  logic [7:0] dinS1Q, dinS2Q;
  logic abtS1Q, abtS2Q;
  logic [TICK_W-1:0] tickQ, tickD;
  logic [2:0] cycleStepQ, cycleStepD;
  logic [7:0] opcodeLatchQ, opcodeLatchD;
  logic [15:0] pcQ, pcD, accQ, accD;
  logic [7:0] pQ, pD;
  logic eQ, eD;
  logic [7:0] dataBankQ, dataBankD;
  logic [7:0] opLoQ, opLoD, opHiQ, opHiD;
  logic [7:0] dLoQ, dLoD, dHiQ, dHiD;
  logic abortPendQ, abortPendD;
  logic runQ, runD;
  logic ackQ, ackD;
  logic [31:0] rdataQ, rdataD;
  logic [15:0] addrQ, addrD;
  logic [7:0] doutQ, doutD;
  logic oeNQ, oeND, rnwQ, rnwD;
  logic vdaQ, vdaD, vpaQ, vpaD, vecNQ, vecND;
  ccd_bus_t busKind;
  logic lastStep, srcMem;
  ccd_alu_t aluOp;
  ccd_tgt_t target;
  logic wide8, cycleEnd, firstHalf, fire, inhibit, wbReq;
  logic [7:0] opLoN, opHiN, dLoN, dHiN, bankSel;
  logic [15:0] aluRes, dataAddr, vecAddr;
  logic aluC, aluN, aluV, aluZ;

  assign wide8 = pQ[P_M] | eQ;
  assign cycleEnd = (tickQ == LAST_TICK);
  assign firstHalf = (tickQ < HALF_TICK);
  assign fire = runQ && cycleEnd;
  assign inhibit = abortPendQ || !abtS2Q;
  assign wbReq = cyc_i && stb_i && !ackQ;

  ccd_decode decoder (
    .opcode(opcodeLatchQ),
    .step(cycleStepQ),
    .wide8(wide8),
    .busKind(busKind),
    .lastStep(lastStep),
    .aluOp(aluOp),
    .target(target),
    .srcMem(srcMem)
  );

  ccd_alu alu (
    .opA(accQ),
    .opB(srcMem ? {dHiN, dLoN} : {opHiN, opLoN}),
    .carryIn(pQ[P_C]),
    .aluOp(aluOp),
    .wide8(wide8),
    .result(aluRes),
    .carryOut(aluC),
    .negOut(aluN),
    .ovfOut(aluV),
    .zeroOut(aluZ)
  );

  // operand bytes including the byte arriving this cycle
  always_comb
  begin
    opLoN = opLoQ;
    opHiN = opHiQ;
    dLoN = dLoQ;
    dHiN = dHiQ;
    if (busKind == BUS_PROG || busKind == BUS_VEC)
    begin
      if (cycleStepQ == 3'd1)
        opLoN = dinS2Q;
      if (cycleStepQ == 3'd2)
        opHiN = dinS2Q;
    end
    if (busKind == BUS_DREAD)
    begin
      if (cycleStepQ == 3'd3)
        dLoN = dinS2Q;
      if (cycleStepQ == 3'd4)
        dHiN = dinS2Q;
    end
  end

  // instruction sequencing and execution
  always_comb
  begin
    tickD = tickQ;
    cycleStepD = cycleStepQ;
    opcodeLatchD = opcodeLatchQ;
    pcD = pcQ;
    accD = accQ;
    pD = pQ;
    eD = eQ;
    dataBankD = dataBankQ;
    opLoD = opLoQ;
    opHiD = opHiQ;
    dLoD = dLoQ;
    dHiD = dHiQ;
    abortPendD = abortPendQ;
    if (runQ)
      tickD = cycleEnd ? '0 : tickQ + TICK_W'(1);
    if (fire)
    begin
      opLoD = opLoN;
      opHiD = opHiN;
      dLoD = dLoN;
      dHiD = dHiN;
      if (busKind == BUS_PROG)
        pcD = pcQ + 16'h0001;
      if (cycleStepQ == 3'd0)
      begin
        opcodeLatchD = dinS2Q;
        cycleStepD = 3'd1;
        abortPendD = 1'b0;
      end
      else if (lastStep)
      begin
        cycleStepD = 3'd0;
        if (!inhibit)
        begin
          case (target)
            TGT_ACC, TGT_FLAGS:
            begin
              if (target == TGT_ACC)
              begin
                if (wide8)
                  accD[7:0] = aluRes[7:0];
                else
                  accD = aluRes;
              end
              pD[P_N] = aluN;
              pD[P_Z] = aluZ;
              if (aluOp == ALU_ADD || aluOp == ALU_SUB ||
                  aluOp == ALU_CMP)
                pD[P_C] = aluC;
              if (aluOp == ALU_ADD || aluOp == ALU_SUB)
                pD[P_V] = aluV;
            end
            TGT_SWAP:
            begin
              accD = {accQ[7:0], accQ[15:8]};
              pD[P_N] = accQ[15];
              pD[P_Z] = (accQ[15:8] == 8'h00);
            end
            TGT_XCE:
            begin
              eD = pQ[P_C];
              pD[P_C] = eQ;
            end
            TGT_CLC: pD[P_C] = 1'b0;
            TGT_SEC: pD[P_C] = 1'b1;
            TGT_REP: pD = pQ & ~opLoN;
            TGT_SEP: pD = pQ | opLoN;
            TGT_BANK: dataBankD = opLoN;
            TGT_JUMP: pcD = {opHiN, opLoN};
            default: ;
          endcase
        end
      end
      else
        cycleStepD = cycleStepQ + 3'd1;
    end
    if (!abtS2Q)
      abortPendD = 1'b1;
    if (eD)
    begin
      pD[P_M] = 1'b1;
      pD[P_X] = 1'b1;
    end
  end

  // external bus pins, registered
  always_comb
  begin
    dataAddr = {opHiQ, opLoQ} + {15'h0000, cycleStepQ == 3'd4};
    vecAddr = BRK_VECTOR + {15'h0000, cycleStepQ == 3'd2};
    addrD = pcQ;
    bankSel = PROG_BANK;
    case (busKind)
      BUS_DREAD, BUS_DWRITE:
      begin
        addrD = dataAddr;
        bankSel = dataBankQ;
      end
      BUS_VEC:
      begin
        addrD = vecAddr;
        bankSel = VEC_BANK;
      end
      default: ;
    endcase
    oeND = 1'b1;
    doutD = doutQ;
    if (runQ && firstHalf)
    begin
      oeND = 1'b0;
      doutD = bankSel;
    end
    else if (runQ && busKind == BUS_DWRITE)
    begin
      oeND = 1'b0;
      doutD = (cycleStepQ == 3'd3) ? accQ[7:0] : accQ[15:8];
    end
    rnwD = (busKind != BUS_DWRITE);
    vpaD = runQ && (busKind == BUS_PROG);
    vdaD = runQ && (busKind == BUS_DREAD || busKind == BUS_DWRITE ||
                    busKind == BUS_VEC ||
                    (busKind == BUS_PROG && cycleStepQ == 3'd0));
    vecND = !(runQ && busKind == BUS_VEC);
  end

  // wishbone slave
  always_comb
  begin
    runD = runQ;
    ackD = wbReq;
    rdataD = rdataQ;
    if (wbReq && we_i && adr_i == REG_CTRL && sel_i[0])
      runD = dat_i[CTRL_RUN_BIT];
    if (wbReq)
    begin
      rdataD = 32'h0000_0000;
      if (adr_i == REG_CTRL)
        rdataD[CTRL_RUN_BIT] = runQ;
      else if (adr_i == REG_STATUS)
      begin
        rdataD[STAT_P_LSB +: 8] = pQ;
        rdataD[STAT_E_BIT] = eQ;
        rdataD[STAT_STEP_LSB +: 3] = cycleStepQ;
        rdataD[STAT_ABORT_BIT] = abortPendQ;
        rdataD[STAT_RUN_BIT] = runQ;
        rdataD[STAT_OPC_LSB +: 8] = opcodeLatchQ;
      end
      else if (adr_i == REG_ACC)
        rdataD[15:0] = accQ;
      else if (adr_i == REG_BANK)
        rdataD[7:0] = dataBankQ;
      else if (adr_i == REG_PC)
        rdataD[15:0] = pcQ;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dinS1Q <= 8'h00;
      dinS2Q <= 8'h00;
      abtS1Q <= 1'b1;
      abtS2Q <= 1'b1;
      tickQ <= '0;
      cycleStepQ <= 3'd0;
      opcodeLatchQ <= OPC_RESET;
      pcQ <= PC_RESET;
      accQ <= ACC_RESET;
      pQ <= P_RESET;
      eQ <= E_RESET;
      dataBankQ <= BANK_RESET;
      opLoQ <= 8'h00;
      opHiQ <= 8'h00;
      dLoQ <= 8'h00;
      dHiQ <= 8'h00;
      abortPendQ <= 1'b0;
      runQ <= CTRL_RUN_RESET;
      ackQ <= 1'b0;
      rdataQ <= 32'h0000_0000;
      addrQ <= 16'h0000;
      doutQ <= 8'h00;
      oeNQ <= 1'b1;
      rnwQ <= 1'b1;
      vdaQ <= 1'b0;
      vpaQ <= 1'b0;
      vecNQ <= 1'b1;
    end
    else if (ce)
    begin
      dinS1Q <= dataIn;
      dinS2Q <= dinS1Q;
      abtS1Q <= abortInput_n;
      abtS2Q <= abtS1Q;
      tickQ <= tickD;
      cycleStepQ <= cycleStepD;
      opcodeLatchQ <= opcodeLatchD;
      pcQ <= pcD;
      accQ <= accD;
      pQ <= pD;
      eQ <= eD;
      dataBankQ <= dataBankD;
      opLoQ <= opLoD;
      opHiQ <= opHiD;
      dLoQ <= dLoD;
      dHiQ <= dHiD;
      abortPendQ <= abortPendD;
      runQ <= runD;
      ackQ <= ackD;
      rdataQ <= rdataD;
      addrQ <= addrD;
      doutQ <= doutD;
      oeNQ <= oeND;
      rnwQ <= rnwD;
      vdaQ <= vdaD;
      vpaQ <= vpaD;
      vecNQ <= vecND;
    end
  end

  assign dat_o = rdataQ;
  assign ack_o = ackQ;
  assign addrOut = addrQ;
  assign dataOut = doutQ;
  assign dataOe_n = oeNQ;
  assign readNotWrite = rnwQ;
  assign validDataAddr = vdaQ;
  assign validProgramAddr = vpaQ;
  assign vectorFetch_n = vecNQ;
  assign emulationOut = eQ;
endmodule : ccd_core

// ==== design/ccd_pkg.sv ====
// constants and types shared by the cpu core datapath files
package ccd_pkg;
  // bus cycle timing: clocks per half memory cycle
  localparam int HALF_TICKS = 4;
  localparam int TICK_W = 4;
  // register offsets on the wishbone slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_P_LSB = 0;
  localparam int STAT_E_BIT = 8;
  localparam int STAT_STEP_LSB = 9;
  localparam int STAT_ABORT_BIT = 12;
  localparam int STAT_RUN_BIT = 13;
  localparam int STAT_OPC_LSB = 16;
  // status flag positions
  localparam int P_C = 0;
  localparam int P_Z = 1;
  localparam int P_X = 4;
  localparam int P_M = 5;
  localparam int P_V = 6;
  localparam int P_N = 7;
  // reset values
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] P_RESET = 8'h34;
  localparam logic E_RESET = 1'b1;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] OPC_RESET = 8'hEA;
  // fixed banks and vector
  localparam logic [7:0] PROG_BANK = 8'h00;
  localparam logic [7:0] VEC_BANK = 8'h00;
  localparam logic [15:0] BRK_VECTOR = 16'hFFE6;
  // operation codes with dedicated handling
  localparam logic [7:0] OPC_LDA_IMM = 8'hA9;
  localparam logic [7:0] OPC_ADC_IMM = 8'h69;
  localparam logic [7:0] OPC_SBC_IMM = 8'hE9;
  localparam logic [7:0] OPC_AND_IMM = 8'h29;
  localparam logic [7:0] OPC_ORA_IMM = 8'h09;
  localparam logic [7:0] OPC_EOR_IMM = 8'h49;
  localparam logic [7:0] OPC_CMP_IMM = 8'hC9;
  localparam logic [7:0] OPC_LDA_ABS = 8'hAD;
  localparam logic [7:0] OPC_STA_ABS = 8'h8D;
  localparam logic [7:0] OPC_SWAP = 8'hEB;
  localparam logic [7:0] OPC_XCE = 8'hFB;
  localparam logic [7:0] OPC_CLC = 8'h18;
  localparam logic [7:0] OPC_SEC = 8'h38;
  localparam logic [7:0] OPC_REP = 8'hC2;
  localparam logic [7:0] OPC_SEP = 8'hE2;
  localparam logic [7:0] OPC_BANK_IMM = 8'hAB;
  localparam logic [7:0] OPC_BRK = 8'h00;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_PROG, BUS_DREAD, BUS_DWRITE, BUS_VEC
  } ccd_bus_t;
  typedef enum logic [2:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CMP
  } ccd_alu_t;
  typedef enum logic [3:0] {
    TGT_NONE, TGT_ACC, TGT_FLAGS, TGT_MEM, TGT_SWAP, TGT_XCE,
    TGT_CLC, TGT_SEC, TGT_REP, TGT_SEP, TGT_BANK, TGT_JUMP
  } ccd_tgt_t;
endpackage : ccd_pkg

// ==== design/ccd_alu.sv ====
// 16-bit arithmetic and logic unit with 8-bit width mode
`timescale 1ns/100ps
module ccd_alu
  import ccd_pkg::*;
(
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  input wire logic carryIn,
  input wire ccd_alu_t aluOp,
  input wire logic wide8,
  output logic [15:0] result,
  output logic carryOut,
  output logic negOut,
  output logic ovfOut,
  output logic zeroOut
);
  logic [15:0] bOp;
  logic cin;
  logic [16:0] sum;
  logic [8:0] sumLo;

  always_comb
  begin
    bOp = opB;
    cin = carryIn;
    case (aluOp)
      ALU_SUB: bOp = ~opB;
      ALU_CMP:
      begin
        bOp = ~opB;
        cin = 1'b1;
      end
      default: ;
    endcase
    sum = {1'b0, opA} + {1'b0, bOp} + {16'h0000, cin};
    sumLo = {1'b0, opA[7:0]} + {1'b0, bOp[7:0]} + {8'h00, cin};
    case (aluOp)
      ALU_ADD, ALU_SUB, ALU_CMP: result = sum[15:0];
      ALU_AND: result = opA & opB;
      ALU_OR: result = opA | opB;
      ALU_XOR: result = opA ^ opB;
      default: result = opB;
    endcase
    // narrow mode takes flags from the low byte only
    if (wide8)
    begin
      carryOut = sumLo[8];
      negOut = result[7];
      zeroOut = (result[7:0] == 8'h00);
      ovfOut = (opA[7] == bOp[7]) && (result[7] != opA[7]);
    end
    else
    begin
      carryOut = sum[16];
      negOut = result[15];
      zeroOut = (result == 16'h0000);
      ovfOut = (opA[15] == bOp[15]) && (result[15] != opA[15]);
    end
  end
endmodule : ccd_alu

// ==== design/ccd_decode.sv ====
// opcode and cycle step decoder for the core control section
`timescale 1ns/100ps
module ccd_decode
  import ccd_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [2:0] step,
  input wire logic wide8,
  output ccd_bus_t busKind,
  output logic lastStep,
  output ccd_alu_t aluOp,
  output ccd_tgt_t target,
  output logic srcMem
);
  logic isImm;
  logic isAbs;
  logic isByte;

  always_comb
  begin
    aluOp = ALU_PASS;
    target = TGT_NONE;
    srcMem = 1'b0;
    isImm = 1'b1;
    isAbs = 1'b0;
    isByte = 1'b0;
    case (opcode)
      OPC_LDA_IMM: target = TGT_ACC;
      OPC_ADC_IMM:
      begin
        aluOp = ALU_ADD;
        target = TGT_ACC;
      end
      OPC_SBC_IMM:
      begin
        aluOp = ALU_SUB;
        target = TGT_ACC;
      end
      OPC_AND_IMM:
      begin
        aluOp = ALU_AND;
        target = TGT_ACC;
      end
      OPC_ORA_IMM:
      begin
        aluOp = ALU_OR;
        target = TGT_ACC;
      end
      OPC_EOR_IMM:
      begin
        aluOp = ALU_XOR;
        target = TGT_ACC;
      end
      OPC_CMP_IMM:
      begin
        aluOp = ALU_CMP;
        target = TGT_FLAGS;
      end
      default:
      begin
        isImm = 1'b0;
        case (opcode)
          OPC_LDA_ABS:
          begin
            target = TGT_ACC;
            srcMem = 1'b1;
            isAbs = 1'b1;
          end
          OPC_STA_ABS:
          begin
            target = TGT_MEM;
            isAbs = 1'b1;
          end
          OPC_SWAP: target = TGT_SWAP;
          OPC_XCE: target = TGT_XCE;
          OPC_CLC: target = TGT_CLC;
          OPC_SEC: target = TGT_SEC;
          OPC_REP:
          begin
            target = TGT_REP;
            isByte = 1'b1;
          end
          OPC_SEP:
          begin
            target = TGT_SEP;
            isByte = 1'b1;
          end
          OPC_BANK_IMM:
          begin
            target = TGT_BANK;
            isByte = 1'b1;
          end
          OPC_BRK: target = TGT_JUMP;
          // every other code runs as a no-operation: opcode fetch plus one idle cycle
          default: ;
        endcase
      end
    endcase
    busKind = BUS_IDLE;
    lastStep = 1'b1;
    if (step == 3'd0)
    begin
      busKind = BUS_PROG;
      lastStep = 1'b0;
    end
    else if (isImm)
    begin
      busKind = BUS_PROG;
      lastStep = wide8 || (step == 3'd2);
    end
    else if (isAbs)
    begin
      if (step < 3'd3)
      begin
        busKind = BUS_PROG;
        lastStep = 1'b0;
      end
      else
      begin
        busKind = (target == TGT_MEM) ? BUS_DWRITE : BUS_DREAD;
        lastStep = wide8 || (step == 3'd4);
      end
    end
    else if (isByte)
      busKind = BUS_PROG;
    else if (target == TGT_JUMP)
    begin
      busKind = BUS_VEC;
      lastStep = (step == 3'd2);
    end
  end
endmodule : ccd_decode

// ==== bench/ccd_core_assertions.sv ====
// concurrent checks on the core's top-level pins
`timescale 1ns/100ps
module ccd_core_assertions
  import ccd_pkg::*;
#(
  parameter int HALF = HALF_TICKS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [15:0] addrOut,
  input wire logic [7:0] dataOut,
  input wire logic dataOe_n,
  input wire logic readNotWrite,
  input wire logic validDataAddr,
  input wire logic validProgramAddr,
  input wire logic vectorFetch_n,
  input wire logic emulationOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ack_one_cycle_a:
    assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_next_cycle_a:
    assert property (ce && cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  reset_idle_a:
    assert property (disable iff (1'b0) rst |=> dataOe_n && vectorFetch_n
      && emulationOut && !validDataAddr && !validProgramAddr)
    else $error("pins not idle after reset");
  vector_read_a:
    assert property (!vectorFetch_n |-> validDataAddr && readNotWrite
      && !validProgramAddr)
    else $error("vector fetch outside a data read");
  write_drive_a:
    assert property (validDataAddr && !readNotWrite |-> !dataOe_n)
    else $error("data lines released in a write cycle");
  bank_half_a:
    assert property ($fell(dataOe_n) && readNotWrite
      |-> !dataOe_n [*4] ##1 dataOe_n)
    else $error("bank half of a read has wrong length");
  prog_bank_a:
    assert property ((validProgramAddr || !vectorFetch_n) && !dataOe_n
      |-> dataOut == (validProgramAddr ? PROG_BANK : VEC_BANK))
    else $error("wrong bank byte on program or vector cycle");
  addr_stands_a:
    assert property ($changed(addrOut) |=> ($stable(addrOut)
      && $stable(validDataAddr) && $stable(readNotWrite)) [*7])
    else $error("address or cycle kind changed mid cycle");
endmodule : ccd_core_assertions

bind ccd_core ccd_core_assertions #(.HALF(HALF)) i_chk (
  .clk(clk), .rst(rst), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .addrOut(addrOut), .dataOut(dataOut),
  .dataOe_n(dataOe_n), .readNotWrite(readNotWrite),
  .validDataAddr(validDataAddr), .validProgramAddr(validProgramAddr),
  .vectorFetch_n(vectorFetch_n), .emulationOut(emulationOut)
);

// ==== bench/ccd_mem_model.sv ====
// external memory on the shared bank and data lines
`timescale 1ns/100ps
module ccd_mem_model
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] addrOut,
  input wire logic [7:0] dataOut,
  input wire logic dataOe_n,
  input wire logic readNotWrite,
  input wire logic validDataAddr,
  input wire logic validProgramAddr,
  output logic [7:0] dataIn
);
  logic [7:0] mem [logic [23:0]];
  logic [7:0] bank = 8'h00;
  logic [7:0] junk = 8'h5A;
  logic [15:0] lastAddr = 16'h0000;

  function automatic logic [7:0] peek(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : peek

  task automatic put(input logic [23:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask : put

  // bank byte taken in the first half, write data lands last
  always @(posedge clk)
  begin
    lastAddr <= addrOut;
    junk <= ~junk;
    if (!dataOe_n && (readNotWrite || addrOut != lastAddr))
      bank <= dataOut;
    if (validDataAddr && !readNotWrite && !dataOe_n && addrOut == lastAddr)
      mem[{bank, addrOut}] = dataOut;
  end

  // released lines show a changing pattern, not the last byte
  assign dataIn = ((validDataAddr | validProgramAddr) & readNotWrite
    & dataOe_n) === 1'b1 ? peek({bank, addrOut}) : junk;
endmodule : ccd_mem_model

// ==== bench/cpu_core_datapath_control_test.sv ====
// self-checking bench for the cpu core datapath and control
`timescale 1ns/100ps
module cpu_core_datapath_control_test
  import ccd_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic abortN = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic ack, dataOe_n, rnw, valid_data_addr, valid_program_addr, vecN, emu;
  logic [15:0] addrOut, w, m;
  logic [7:0] dataIn, dataOut, r1, r2, b, k1, k2, k3, k4, k5, x;
  logic [16:0] sum;
  logic [8:0] d;
  logic [7:0] prog [0:33];
  int seed = 32'h9005;
  int errorCnt = 0;
  int checksDone = 0;
  int vecSeen = 0;
  int n, p;

  always #2.5 clk = ~clk;

  ccd_core i_dut (
    .clk(clk), .rst(rst), .ce(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .addrOut(addrOut), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe_n(dataOe_n), .readNotWrite(rnw), .validDataAddr(valid_data_addr),
    .validProgramAddr(valid_program_addr), .vectorFetch_n(vecN),
    .abortInput_n(abortN), .emulationOut(emu)
  );
  ccd_mem_model i_mem (
    .clk(clk), .addrOut(addrOut), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .readNotWrite(rnw), .validDataAddr(valid_data_addr), .validProgramAddr(valid_program_addr),
    .dataIn(dataIn)
  );

  always @(posedge clk)
    if (vecN === 1'b0)
      vecSeen <= vecSeen + 1;

  task automatic final_report;
    $display("errors %0d checks %0d", errorCnt, checksDone);
    if (errorCnt == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic wb(input logic wr, input logic [7:0] a,
    input logic [31:0] dw);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= dw;
    for (n = 0; n < 40 && ack !== 1'b1; n++)
      @(posedge clk);
    check("ack within bound", 32'h0000_0001, 32'(n < 40));
    if (n == 40)
      final_report();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // flags after the closing compare in 8-bit mode
  function automatic logic [31:0] cmpFlags(input logic [7:0] a,
    input logic [7:0] c);
    logic [7:0] t;
    t = a - c;
    cmpFlags = 32'h0000_0000;
    cmpFlags[P_N] = t[7];
    cmpFlags[P_Z] = (t == 8'h00);
    cmpFlags[P_C] = (a >= c);
    cmpFlags[P_M] = 1'b1;
    cmpFlags[P_X] = 1'b1;
  endfunction : cmpFlags

  initial
  begin
    r1 = 8'($random(seed)) | 8'h01;
    r2 = 8'($random(seed));
    b = 8'($random(seed));
    k1 = 8'($random(seed));
    k2 = 8'($random(seed));
    k3 = 8'($random(seed));
    k4 = 8'($random(seed));
    k5 = 8'($random(seed));
    w = 16'($random(seed));
    m = 16'($random(seed));
    prog = '{OPC_LDA_IMM, r1, OPC_ADC_IMM, r2, OPC_SWAP, OPC_CLC, OPC_XCE,
      OPC_REP, 8'h20, OPC_ADC_IMM, w[7:0], w[15:8], OPC_BANK_IMM, b,
      OPC_STA_ABS, 8'h00, 8'h20, OPC_LDA_ABS, 8'h00, 8'h30, OPC_SEP,
      8'h20, OPC_AND_IMM, k1, OPC_ORA_IMM, k2, OPC_EOR_IMM, k3,
      OPC_SBC_IMM, k4, OPC_CMP_IMM, k5, OPC_BRK, 8'h00};
    for (p = 0; p < 34; p++)
      i_mem.put(24'(p), prog[p]);
    i_mem.put(24'h00_0040, OPC_BRK);
    i_mem.put({VEC_BANK, BRK_VECTOR}, 8'h40);
    i_mem.put({VEC_BANK, BRK_VECTOR + 16'h0001}, 8'h00);
    i_mem.put({b, 16'h3000}, m[7:0]);
    i_mem.put({b, 16'h3001}, m[15:8]);
    sum = {1'b0, r1 + r2, 8'h00} + {1'b0, w} + 17'h0_0001;
    x = ((m[7:0] & k1) | k2) ^ k3;
    d = {1'b0, x} - {1'b0, k4} - {8'h00, !sum[16]};
    x = d[7:0];
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, q);
    wb(1'b0, REG_CTRL, 32'h0000_0000);
    check("run after reset", 32'h0000_0001, q);
    for (p = 0; p < 12; p++)
    begin
      wb(1'b0, REG_ACC, 32'h0000_0000);
      check("acc under abort", 32'h0000_0000, q);
    end
    // aborted start left the program half done: restart it from reset
    abortN <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (p = 0; p < 600 && q[15:1] !== 15'h0020; p++)
      wb(1'b0, REG_PC, 32'h0000_0000);
    check("program end", 32'h0000_0040,
      {16'h0000, q[15:1], 1'b0});
    if (p == 600)
      final_report();
    wb(1'b1, REG_ACC, 32'hFFFF_FFFF);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, REG_ACC, 32'h0000_0000);
    check("accumulator", {16'h0000, m[15:8], x}, q);
    wb(1'b0, REG_BANK, 32'h0000_0000);
    check("data bank", {24'h00_0000, b}, q);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    check("status", cmpFlags(x, k5), q & 32'h00FF_01B3);
    check("stored low", 32'(sum[7:0]),
      32'(i_mem.peek({b, 16'h2000})));
    check("stored high", 32'(sum[15:8]),
      32'(i_mem.peek({b, 16'h2001})));
    check("native pin", 32'h0000_0000, 32'(emu));
    check("vector reads", 32'h0000_0001, 32'(vecSeen != 0));
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_BANK, 32'h0000_0000);
    check("bank after reset", 32'h0000_0000, q);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    check("modes after reset", {23'h0, E_RESET, P_RESET},
      q & 32'h0000_01FF);
    check("emulation pin", 32'h0000_0001, 32'(emu));
    final_report();
  end
endmodule : cpu_core_datapath_control_test
